// File: logic/stepper_ctl_pkg.sv
// constants, register map and types for the stepper control word handler
package stepper_ctl_pkg;
    // control word codes
    localparam logic [2:0] CW_ENABLE = 3'h1;
    localparam logic [2:0] CW_PAUSE = 3'h2;
    localparam logic [2:0] CW_CONTINUE = 3'h3;
    localparam logic [2:0] CW_ESTOP = 3'h4;
    localparam logic [2:0] CW_CSTOP = 3'h5;
    localparam logic [2:0] CW_STEPDIR = 3'h6;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CMD_COUNT = 8'h08;
    localparam logic [7:0] OFS_CMD_PUSH = 8'h0C;
    localparam logic [7:0] OFS_RATE = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFS_POSITION = 8'h1C;
    // status word bit positions
    localparam int ST_ENABLED = 0;
    localparam int ST_PAUSED = 1;
    localparam int ST_AT_VEL = 2;
    localparam int ST_QEMPTY = 3;
    localparam int ST_QFULL = 4;
    localparam int ST_NOT_PROC = 5;
    localparam int ST_BAD_CW = 6;
    localparam int ST_STEPDIR = 7;
    // interrupt event bit positions
    localparam int IRQ_CW_DONE = 0;
    localparam int IRQ_QEMPTY = 1;
    localparam int IRQ_BAD_CW = 2;
    localparam int IRQ_OVERFLOW = 3;
    localparam int IRQ_W = 4;
    // command push field layout
    localparam int PUSH_PER_LSB = 0;
    localparam int PUSH_DIR_BIT = 16;
    localparam int PUSH_TYPE_LSB = 24;
    // queue
    localparam int QDEPTH = 500;
    localparam logic [8:0] QLAST = 9'h1F3;
    localparam logic [8:0] QFULL_CNT = 9'h1F4;
    // motion
    localparam logic [15:0] START_PERIOD = 16'h1000;
    localparam logic [15:0] MIN_PERIOD = 16'h0008;
    localparam logic [1:0] STEP_HI_CYC = 2'h2;
    localparam logic [15:0] RATE_RST = 16'h0010;
    // control word must be applied within this time
    localparam int CLK_MHZ = 10;
    localparam int PROC_LIMIT_US = 3000;
    localparam int PROC_LIMIT_CYC = PROC_LIMIT_US * CLK_MHZ;

    typedef enum logic [1:0] {CMD_DIST = 2'h0, CMD_POS = 2'h1, CMD_VEL = 2'h2} cmd_kind_t;
    typedef enum logic [1:0] {MV_IDLE = 2'b00, MV_RUN = 2'b01, MV_DECEL = 2'b11} mv_state_t;

    typedef struct packed {
        logic [1:0] kind;
        logic dir;
        logic [15:0] period;
        logic [23:0] count;
    } cmd_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
endpackage

// File: logic/stepper_control_word_handler.sv
// control word interpreter, command queue and step generator for one stepper axis
// Overview of operation
// RULE1: queue accepts commands only after enable
// RULE2: pause stops starting further queued commands
// RULE3: active distance/position command finishes despite pause
// RULE4: continue clears paused, moves to next command
// RULE5: continue during a command aborts it, starts next
// RULE6: emergency stop halts pulses now, empties queue
// RULE7: controlled stop ramps down, empties queue
// RULE8: step/direction output mode, active by default
// RULE9: control word handled within 3 ms, flagged
// RULE10: host waits for not-processed clear before writing
// RULE11: continue on lone velocity: queue-empty, decelerate
// RULE12: enabled status bit set by enable word
// RULE13: paused bit set by pause, cleared by continue
// RULE14: 500-entry queue, full flag, overflow estops
// RULE15: unknown control code rejected, error flagged
// RULE16: not-processed set on write, cleared when applied
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
module stepper_control_word_handler (
    input wire logic pclk, // apb clock, 10 MHz
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, high for write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    output logic step_cw, // step pulse output
    output logic dir_ccw, // direction level output
    output logic irq // level interrupt
);
    localparam int IRQ_W_L = stepper_ctl_pkg::IRQ_W;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] cw_code;
        logic cw_pend;
        logic enabled;
        logic paused;
        logic at_vel;
        logic qempty;
        logic bad_cw;
        logic stepdir;
        logic cstop_pend;
        logic [23:0] arg_count;
        logic [15:0] rate;
        logic [IRQ_W_L-1:0] irq_stat;
        logic [IRQ_W_L-1:0] irq_mask;
        logic irq;
        logic [8:0] wr_ptr;
        logic [8:0] rd_ptr;
        logic [8:0] qcnt;
        stepper_ctl_pkg::mv_state_t mv;
        logic [1:0] kind;
        logic [23:0] remain;
        logic [15:0] tgt_period;
        logic [15:0] cur_period;
        logic [15:0] timer;
        logic [1:0] hi_cnt;
        logic step;
        logic dir;
        logic [31:0] position;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    stepper_ctl_pkg::cmd_t queue_mem [stepper_ctl_pkg::QDEPTH];
    stepper_ctl_pkg::cmd_t head;
    stepper_ctl_pkg::cmd_t push_cmd;
    stepper_ctl_pkg::apb_req_t req;
    logic push_ok;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign head = queue_mem[st_r.rd_ptr];
    assign push_cmd = '{
        kind: pwdata[stepper_ctl_pkg::PUSH_TYPE_LSB +: 2],
        dir: pwdata[stepper_ctl_pkg::PUSH_DIR_BIT],
        period: pwdata[stepper_ctl_pkg::PUSH_PER_LSB +: 16],
        count: st_r.arg_count
    };

    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign step_cw = st_r.step;
    assign dir_ccw = st_r.dir;
    assign irq = st_r.irq;

    function automatic logic [31:0] status_word(input state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[stepper_ctl_pkg::ST_ENABLED] = s.enabled;
        w[stepper_ctl_pkg::ST_PAUSED] = s.paused;
        w[stepper_ctl_pkg::ST_AT_VEL] = s.at_vel;
        w[stepper_ctl_pkg::ST_QEMPTY] = s.qempty;
        w[stepper_ctl_pkg::ST_QFULL] = (s.qcnt == stepper_ctl_pkg::QFULL_CNT);
        w[stepper_ctl_pkg::ST_NOT_PROC] = s.cw_pend;
        w[stepper_ctl_pkg::ST_BAD_CW] = s.bad_cw;
        w[stepper_ctl_pkg::ST_STEPDIR] = s.stepdir;
        return w;
    endfunction

    function automatic logic [8:0] ptr_inc(input logic [8:0] p);
        return (p == stepper_ctl_pkg::QLAST) ? 9'h000 : p + 9'h001;
    endfunction

    always_comb
    begin
        logic setup;
        logic wr;
        logic [4:0] ev;
        logic pop;
        logic flush;
        logic start_next;
        logic step_now;
        logic [31:0] span;
        setup = 1'b0;
        wr = 1'b0;
        ev = 5'h00;
        pop = 1'b0;
        flush = 1'b0;
        start_next = 1'b0;
        step_now = 1'b0;
        span = 32'h0000_0000;
        push_ok = 1'b0;
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;

        // apb slave: answer in the first access cycle, writes land at its ready edge
        setup = req.psel && !req.penable;
        wr = req.psel && req.penable && req.pwrite && st_r.pready;
        if (setup)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h0000_0000;
            unique case (req.paddr)
                stepper_ctl_pkg::OFS_CTRL:
                    st_nxt.prdata = {29'h0000_0000, st_r.cw_code};
                stepper_ctl_pkg::OFS_STATUS:
                    st_nxt.prdata = status_word(st_r);
                stepper_ctl_pkg::OFS_CMD_COUNT:
                    st_nxt.prdata = {8'h00, st_r.arg_count};
                stepper_ctl_pkg::OFS_CMD_PUSH:
                    st_nxt.prdata = {23'h00_0000, st_r.qcnt};
                stepper_ctl_pkg::OFS_RATE:
                    st_nxt.prdata = {16'h0000, st_r.rate};
                stepper_ctl_pkg::OFS_IRQ_STAT:
                    st_nxt.prdata = {28'h000_0000, st_r.irq_stat};
                stepper_ctl_pkg::OFS_IRQ_MASK:
                    st_nxt.prdata = {28'h000_0000, st_r.irq_mask};
                stepper_ctl_pkg::OFS_POSITION:
                    st_nxt.prdata = st_r.position;
                default:
                    st_nxt.pslverr = 1'b1;
            endcase
        end

        if (wr)
        begin
            unique case (req.paddr)
                stepper_ctl_pkg::OFS_CTRL:
                begin
                    if (!st_r.cw_pend)
                    begin
                        st_nxt.cw_code = req.pwdata[2:0];
                        st_nxt.cw_pend = 1'b1; // RULE16
                    end
                end
                stepper_ctl_pkg::OFS_CMD_COUNT:
                    st_nxt.arg_count = req.pwdata[23:0];
                stepper_ctl_pkg::OFS_CMD_PUSH:
                begin
                    if (!st_r.enabled)
                        ev[stepper_ctl_pkg::IRQ_BAD_CW] = 1'b1; // RULE1
                    else if (st_r.qcnt == stepper_ctl_pkg::QFULL_CNT)
                    begin
                        // overflow acts as an emergency stop
                        ev[stepper_ctl_pkg::IRQ_OVERFLOW] = 1'b1; // RULE14
                        flush = 1'b1;
                        st_nxt.enabled = 1'b0;
                        st_nxt.mv = stepper_ctl_pkg::MV_IDLE;
                        st_nxt.step = 1'b0;
                    end
                    else
                    begin
                        push_ok = 1'b1; // RULE1
                        st_nxt.qempty = 1'b0;
                    end
                end
                stepper_ctl_pkg::OFS_RATE:
                    st_nxt.rate = req.pwdata[15:0];
                stepper_ctl_pkg::OFS_IRQ_MASK:
                    st_nxt.irq_mask = req.pwdata[IRQ_W_L-1:0];
                default:
                begin
                end
            endcase
        end

        // step pulse width and period timer
        if (st_r.hi_cnt != 2'h0)
            st_nxt.hi_cnt = st_r.hi_cnt - 2'h1;
        else
            st_nxt.step = 1'b0;
        if (st_r.mv != stepper_ctl_pkg::MV_IDLE)
        begin
            if (st_r.timer == 16'h0000)
            begin
                step_now = 1'b1;
                st_nxt.timer = st_r.cur_period;
                st_nxt.step = 1'b1;
                st_nxt.hi_cnt = stepper_ctl_pkg::STEP_HI_CYC;
                st_nxt.position = st_r.dir ? st_r.position - 32'h0000_0001
                                           : st_r.position + 32'h0000_0001;
            end
            else
                st_nxt.timer = st_r.timer - 16'h0001;
        end

        unique case (st_r.mv)
            stepper_ctl_pkg::MV_IDLE:
                start_next = st_r.enabled && !st_r.paused && st_r.qcnt != 9'h000; // RULE2
            stepper_ctl_pkg::MV_RUN:
            begin
                if (step_now)
                begin
                    // accelerate toward the commanded period
                    if (st_r.cur_period > st_r.tgt_period + st_r.rate)
                        st_nxt.cur_period = st_r.cur_period - st_r.rate;
                    else
                    begin
                        st_nxt.cur_period = st_r.tgt_period;
                        if (st_r.kind == stepper_ctl_pkg::CMD_VEL)
                            st_nxt.at_vel = 1'b1;
                    end
                    if (st_r.kind != stepper_ctl_pkg::CMD_VEL)
                    begin
                        st_nxt.remain = st_r.remain - 24'h00_0001;
                        // distance/position runs out even while paused
                        if (st_r.remain == 24'h00_0001)
                        begin
                            st_nxt.mv = stepper_ctl_pkg::MV_IDLE; // RULE3
                            if (st_r.qcnt == 9'h000)
                            begin
                                st_nxt.qempty = 1'b1;
                                ev[stepper_ctl_pkg::IRQ_QEMPTY] = 1'b1;
                            end
                        end
                    end
                end
            end
            stepper_ctl_pkg::MV_DECEL:
            begin
                if (step_now)
                begin
                    if (st_r.cur_period >= stepper_ctl_pkg::START_PERIOD - st_r.rate)
                    begin
                        st_nxt.mv = stepper_ctl_pkg::MV_IDLE;
                        st_nxt.at_vel = 1'b0;
                        if (st_r.cstop_pend)
                        begin
                            st_nxt.enabled = 1'b0; // RULE7
                            st_nxt.cstop_pend = 1'b0;
                        end
                    end
                    else
                        st_nxt.cur_period = st_r.cur_period + st_r.rate; // RULE7
                end
            end
            default:
                st_nxt.mv = stepper_ctl_pkg::MV_IDLE;
        endcase

        // apply a pending control word one cycle after it was written
        if (st_r.cw_pend)
        begin
            st_nxt.cw_pend = 1'b0; // RULE9
            ev[stepper_ctl_pkg::IRQ_CW_DONE] = 1'b1;
            st_nxt.bad_cw = 1'b0;
            unique case (st_r.cw_code)
                stepper_ctl_pkg::CW_ENABLE:
                    st_nxt.enabled = 1'b1; // RULE12
                stepper_ctl_pkg::CW_PAUSE:
                begin
                    st_nxt.paused = 1'b1; // RULE13
                    start_next = 1'b0; // RULE2
                end
                stepper_ctl_pkg::CW_CONTINUE:
                begin
                    st_nxt.paused = 1'b0; // RULE4
                    st_nxt.at_vel = 1'b0;
                    if (st_r.mv == stepper_ctl_pkg::MV_RUN)
                    begin
                        if (st_r.qcnt != 9'h000 && st_r.enabled)
                            start_next = 1'b1; // RULE5
                        else
                        begin
                            st_nxt.qempty = 1'b1; // RULE11
                            ev[stepper_ctl_pkg::IRQ_QEMPTY] = 1'b1;
                            st_nxt.mv = stepper_ctl_pkg::MV_DECEL; // RULE11
                        end
                    end
                    else if (st_r.mv == stepper_ctl_pkg::MV_IDLE)
                        start_next = st_r.enabled && st_r.qcnt != 9'h000; // RULE4
                end
                stepper_ctl_pkg::CW_ESTOP:
                begin
                    flush = 1'b1; // RULE6
                    start_next = 1'b0;
                    st_nxt.enabled = 1'b0;
                    st_nxt.cstop_pend = 1'b0;
                    st_nxt.at_vel = 1'b0;
                    st_nxt.mv = stepper_ctl_pkg::MV_IDLE; // RULE6
                    st_nxt.step = 1'b0; // RULE6
                    st_nxt.hi_cnt = 2'h0;
                end
                stepper_ctl_pkg::CW_CSTOP:
                begin
                    flush = 1'b1; // RULE7
                    start_next = 1'b0;
                    if (st_r.mv == stepper_ctl_pkg::MV_IDLE)
                        st_nxt.enabled = 1'b0;
                    else
                    begin
                        st_nxt.mv = stepper_ctl_pkg::MV_DECEL; // RULE7
                        st_nxt.cstop_pend = 1'b1;
                    end
                end
                stepper_ctl_pkg::CW_STEPDIR:
                    st_nxt.stepdir = 1'b1; // RULE8
                default:
                begin
                    // unknown code: nothing else changes
                    st_nxt.bad_cw = 1'b1; // RULE15
                    ev[stepper_ctl_pkg::IRQ_BAD_CW] = 1'b1; // RULE15
                end
            endcase
        end

        // load the head command into the step generator
        if (start_next && !flush)
        begin
            pop = 1'b1;
            st_nxt.mv = stepper_ctl_pkg::MV_RUN;
            st_nxt.kind = head.kind;
            st_nxt.tgt_period = (head.period < stepper_ctl_pkg::MIN_PERIOD)
                              ? stepper_ctl_pkg::MIN_PERIOD : head.period;
            if (st_r.mv == stepper_ctl_pkg::MV_IDLE)
            begin
                st_nxt.cur_period = stepper_ctl_pkg::START_PERIOD;
                st_nxt.timer = stepper_ctl_pkg::START_PERIOD;
            end
            st_nxt.dir = head.dir;
            st_nxt.remain = head.count;
            if (head.kind == stepper_ctl_pkg::CMD_POS)
            begin
                span = {8'h00, head.count} - st_nxt.position;
                st_nxt.dir = span[31];
                span = span[31] ? 32'h0000_0000 - span : span;
                st_nxt.remain = span[23:0];
            end
            if (head.kind == stepper_ctl_pkg::CMD_VEL)
                st_nxt.paused = 1'b1;
            else if (st_nxt.remain == 24'h00_0000)
                st_nxt.mv = stepper_ctl_pkg::MV_IDLE;
        end

        // queue pointers
        if (flush)
        begin
            st_nxt.wr_ptr = 9'h000;
            st_nxt.rd_ptr = 9'h000;
            st_nxt.qcnt = 9'h000;
            st_nxt.qempty = 1'b1;
        end
        else
        begin
            // a push in the cycle a command completes keeps the queue non-empty
            if (push_ok)
            begin
                st_nxt.wr_ptr = ptr_inc(st_r.wr_ptr);
                st_nxt.qempty = 1'b0;
            end
            if (pop)
                st_nxt.rd_ptr = ptr_inc(st_r.rd_ptr);
            if (push_ok && !pop)
                st_nxt.qcnt = st_r.qcnt + 9'h001;
            else if (pop && !push_ok)
                st_nxt.qcnt = st_r.qcnt - 9'h001;
        end

        // sticky events: a new event wins over a write-one clear
        if (wr && req.paddr == stepper_ctl_pkg::OFS_IRQ_STAT)
            st_nxt.irq_stat = st_r.irq_stat & ~req.pwdata[IRQ_W_L-1:0];
        st_nxt.irq_stat = st_nxt.irq_stat | ev[IRQ_W_L-1:0];
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
    end

    always_ff @(posedge pclk)
    begin
        if (push_ok)
            queue_mem[st_r.wr_ptr] <= push_cmd;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.qempty <= 1'b1;
            st_r.stepdir <= 1'b1; // RULE8
            st_r.rate <= stepper_ctl_pkg::RATE_RST;
            st_r.mv <= stepper_ctl_pkg::MV_IDLE;
            st_r.cur_period <= stepper_ctl_pkg::START_PERIOD;
            st_r.tgt_period <= stepper_ctl_pkg::START_PERIOD;
        end
        else
            st_r <= st_nxt;
    end
endmodule

// File: testbench/stepper_ctl_chk.sv
// port assertions for the stepper control word handler
`timescale 1ns/100ps
module stepper_ctl_chk (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // write
    input wire logic [7:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic step_cw, // step
    input wire logic dir_ccw, // direction
    input wire logic irq // interrupt
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence cw_s(logic [2:0] code);
        psel && !penable && pwrite && paddr == 8'h00 && pwdata[2:0] == code;
    endsequence
    sequence st_rd_s;
        psel && !penable && !pwrite && paddr == 8'h04;
    endsequence
    ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("ready is not a one-cycle answer");
    ready_cause_a: assert property (pready |-> $past(psel && !penable))
        else $error("ready without a setup cycle");
    bad_addr_a: assert property (setup_s and paddr > 8'h1C |=> pslverr)
        else $error("unmapped address not flagged");
    good_addr_a: assert property (setup_s and paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped address flagged");
    step_width_a: assert property ($rose(step_cw) |-> step_cw[*3] ##1 !step_cw)
        else $error("step pulse width wrong");
    dir_hold_a: assert property (step_cw && $past(step_cw) |-> $stable(dir_ccw))
        else $error("direction moved during a step");
    estop_quiet_a: assert property (cw_s(3'h4) |-> ##5 !step_cw[*8])
        else $error("pulses after emergency stop");
    enable_seen_a: assert property (cw_s(3'h1) ##3 st_rd_s |=> prdata[0])
        else $error("enabled bit missing");
    pause_seen_a: assert property (cw_s(3'h2) ##3 st_rd_s |=> prdata[1])
        else $error("paused bit missing");
    resume_seen_a: assert property (cw_s(3'h3) ##3 st_rd_s |=> !prdata[1])
        else $error("paused bit not cleared");
    bad_code_a: assert property (cw_s(3'h7) ##3 st_rd_s |=> prdata[6])
        else $error("bad code not flagged");
endmodule

// File: testbench/host_model.sv
// bus master model of the host controller
`timescale 1ns/100ps
module host_model (
    input wire logic pclk, // bus clock
    output logic psel, // select
    output logic penable, // access phase
    output logic pwrite, // write
    output logic [7:0] paddr, // byte address
    output logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr // error response
);
    logic resp_err;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // call just after a rising edge; ends one idle cycle later
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        resp_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            tb_stepper_control_word_handler.hang();
        @(posedge pclk);
    endtask
    // no new word until the previous one is applied
    task automatic cw(input logic [2:0] code);
        logic [31:0] q;
        int n;
        xfer(1'b1, stepper_ctl_pkg::OFS_CTRL, {29'h0, code}, q);
        n = 0;
        do
        begin
            xfer(1'b0, stepper_ctl_pkg::OFS_STATUS, 32'h0, q);
            n++;
        end
        while (q[stepper_ctl_pkg::ST_NOT_PROC] !== 1'b0 && n < 10);
        if (n >= 10)
            tb_stepper_control_word_handler.hang();
    endtask
endmodule

// File: testbench/tb_stepper_control_word_handler.sv
// self-checking bench for the stepper control word handler
`timescale 1ns/100ps
module tb_stepper_control_word_handler;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, step_cw, dir_ccw, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, p1;
    int errors, tests_run, i;
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    stepper_control_word_handler stepper_control_word_handler_inst (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .step_cw(step_cw), .dir_ccw(dir_ccw), .irq(irq));
    host_model host_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic conclude();
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic hang();
        errors++;
        conclude();
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        host_model_inst.xfer(1'b1, a, d, x);
    endtask
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        logic [31:0] d;
        host_model_inst.xfer(1'b0, a, 32'h0, d);
        chk(n, d & m, e);
    endtask
    task automatic push(input logic [1:0] k);
        wr(stepper_ctl_pkg::OFS_CMD_PUSH, {6'h0, k, 8'h0, 16'h0008});
    endtask
    task automatic irq_is(input logic e);
        @(negedge pclk);
        chk("irq", {31'h0, irq}, {31'h0, e});
        @(posedge pclk);
    endtask
    task automatic wstep();
        i = 0;
        while (step_cw !== 1'b1 && i < 5000)
        begin
            @(negedge pclk);
            i++;
        end
        if (i >= 5000)
            hang();
        @(posedge pclk);
    endtask
    initial
    begin
        presetn = 1'b0;
        errors = 0;
        tests_run = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc("status", 8'h04, 32'hFF, 32'h88);
        rc("unmapped", 8'h20, 32'hFFFFFFFF, 32'h0);
        chk("pslverr", {31'h0, host_model_inst.resp_err}, 32'h1);
        wr(8'h18, 32'hF);
        push(2'h0);
        rc("queue", 8'h0C, 32'h1FF, 32'h0);
        chk("pslverr", {31'h0, host_model_inst.resp_err}, 32'h0);
        rc("irq_stat", 8'h14, 32'hF, 32'h4);
        irq_is(1'b1);
        wr(8'h14, 32'hF);
        irq_is(1'b0);
        host_model_inst.cw(3'h7);
        rc("status", 8'h04, 32'h41, 32'h40);
        host_model_inst.cw(3'h1);
        rc("status", 8'h04, 32'h41, 32'h01);
        host_model_inst.cw(3'h6);
        rc("status", 8'h04, 32'h81, 32'h81);
        wr(8'h10, 32'hFF8);
        wr(8'h08, 32'h3);
        host_model_inst.cw(3'h2);
        push(2'h0);
        rc("queue", 8'h0C, 32'h1FF, 32'h1);
        rc("status", 8'h04, 32'h2, 32'h2);
        repeat (4200) @(posedge pclk);
        rc("position", 8'h1C, 32'hFFFFFFFF, 32'h0);
        host_model_inst.cw(3'h3);
        rc("status", 8'h04, 32'h2, 32'h0);
        wstep();
        host_model_inst.cw(3'h2);
        repeat (4200) @(posedge pclk);
        rc("position", 8'h1C, 32'hFFFFFFFF, 32'h3);
        for (int k = 0; k < 500; k++)
            push(2'h0);
        rc("queue", 8'h0C, 32'h1FF, 32'h1F4);
        rc("status", 8'h04, 32'h10, 32'h10);
        push(2'h0);
        rc("queue", 8'h0C, 32'h1FF, 32'h0);
        rc("status", 8'h04, 32'h1, 32'h0);
        rc("irq_stat", 8'h14, 32'h8, 32'h8);
        wr(8'h14, 32'hF);
        host_model_inst.cw(3'h1);
        wr(8'h08, 32'h3E8);
        push(2'h0);
        push(2'h0);
        host_model_inst.cw(3'h3);
        wstep();
        host_model_inst.cw(3'h4);
        host_model_inst.xfer(1'b0, 8'h1C, 32'h0, p1);
        repeat (50) @(posedge pclk);
        rc("position", 8'h1C, 32'hFFFFFFFF, p1);
        rc("queue", 8'h0C, 32'h1FF, 32'h0);
        rc("status", 8'h04, 32'h1, 32'h0);
        host_model_inst.cw(3'h1);
        push(2'h0);
        push(2'h0);
        host_model_inst.cw(3'h3);
        wstep();
        host_model_inst.cw(3'h5);
        rc("queue", 8'h0C, 32'h1FF, 32'h0);
        repeat (6000) @(posedge pclk);
        rc("status", 8'h04, 32'h1, 32'h0);
        host_model_inst.cw(3'h1);
        push(2'h2);
        host_model_inst.cw(3'h3);
        rc("status", 8'h04, 32'h8, 32'h8);
        repeat (4200) @(posedge pclk);
        wr(8'h08, 32'h5);
        push(2'h1);
        wstep();
        chk("dir_ccw", {31'h0, dir_ccw}, 32'h1);
        repeat (8400) @(posedge pclk);
        rc("position", 8'h1C, 32'hFFFFFFFF, 32'h5);
        conclude();
    end
endmodule
bind stepper_control_word_handler stepper_ctl_chk chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .step_cw(step_cw),
    .dir_ccw(dir_ccw), .irq(irq));
